// ### common/gs_pkg.sv
// Purpose: shared constants and types for gear scaling and pulse output
// Assumes: settings are sampled during reset (a restart)
// Notes: a setting of zero on its port selects the factory value
package gs_pkg;
    // gear numerator and denominator limits and factory values
    localparam logic [30:0] GS_GEAR_MIN = 31'h00000001;
    localparam logic [30:0] GS_GEAR_MAX = 31'h40000000;
    localparam logic [30:0] GS_NUM_RST = 31'h00000004;
    localparam logic [30:0] GS_DEN_RST = 31'h00000001;
    // ratio window: 1/1000 up to 4000
    localparam logic [11:0] GS_RATIO_LO_DIV = 12'h3E8;
    localparam logic [11:0] GS_RATIO_HI = 12'hFA0;
    // output pulse setting limits and factory value
    localparam logic [30:0] GS_PLS_MIN = 31'h00000010;
    localparam logic [30:0] GS_PLS_MAX = 31'h40000000;
    localparam logic [30:0] GS_PLS_RST = 31'h00000800;
    // quadrature edges per output cycle and per phase a pulse
    localparam int GS_EDGES_CYC = 4;
    localparam logic [1:0] GS_ORG_EDGES = 2'h2;
    // divider width and step count
    localparam int GS_DVD_W = 64;
    localparam logic [6:0] GS_DIV_STEPS = 7'h40;
    // divider states, gray along idle, run, done
    typedef enum logic [1:0] {
        GS_DV_IDLE = 2'b00,
        GS_DV_RUN = 2'b01,
        GS_DV_DONE = 2'b11
    } gs_div_st_t;
endpackage

// ### common/gs_div_if.sv
// Purpose: request and answer lines between scaler and divider
// Assumes: one clock, start is a one-cycle pulse while not busy
// Notes: done is a one-cycle pulse with quotient and remainder valid
interface gs_div_if;
    logic start;
    logic [63:0] dvd;
    logic [30:0] dvs;
    logic busy;
    logic done;
    logic [63:0] quo;
    logic [30:0] rem;
    modport req (output start, dvd, dvs, input busy, done, quo, rem);
    modport srv (input start, dvd, dvs, output busy, done, quo, rem);
endinterface

// ### hdl/gs_div.sv
// Purpose: unsigned restoring divider, one quotient bit per clock
// Assumes: divisor is never zero
// Notes: done follows start by the step count plus one
module gs_div
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // request and answer
    gs_div_if.srv dv
);
    gs_pkg::gs_div_st_t st_r, st_nxt;
    logic [63:0] q_r, q_nxt;
    logic [31:0] rm_r, rm_nxt;
    logic [30:0] d_r, d_nxt;
    logic [6:0] n_r, n_nxt;
    logic [31:0] t;

    // one shift and trial subtract per step
    always_comb
    begin
        st_nxt = st_r;
        q_nxt = q_r;
        rm_nxt = rm_r;
        d_nxt = d_r;
        n_nxt = n_r;
        t = {rm_r[30:0], q_r[63]};
        unique case (st_r)
            gs_pkg::GS_DV_IDLE:
            begin
                if (dv.start)
                begin
                    q_nxt = dv.dvd;
                    d_nxt = dv.dvs;
                    rm_nxt = 32'h00000000;
                    n_nxt = gs_pkg::GS_DIV_STEPS;
                    st_nxt = gs_pkg::GS_DV_RUN;
                end
            end
            gs_pkg::GS_DV_RUN:
            begin
                if (t >= {1'b0, d_r})
                begin
                    rm_nxt = t - {1'b0, d_r};
                    q_nxt = {q_r[62:0], 1'b1};
                end
                else
                begin
                    rm_nxt = t;
                    q_nxt = {q_r[62:0], 1'b0};
                end
                n_nxt = n_r - 7'h01;
                if (n_r == 7'h01)
                    st_nxt = gs_pkg::GS_DV_DONE;
            end
            gs_pkg::GS_DV_DONE: st_nxt = gs_pkg::GS_DV_IDLE;
            default: st_nxt = gs_pkg::GS_DV_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            st_r <= gs_pkg::GS_DV_IDLE;
            q_r <= 64'h0;
            rm_r <= 32'h0;
            d_r <= 31'h1;
            n_r <= 7'h00;
        end
        else
        begin
            st_r <= st_nxt;
            q_r <= q_nxt;
            rm_r <= rm_nxt;
            d_r <= d_nxt;
            n_r <= n_nxt;
        end
    end

    assign dv.busy = (st_r != gs_pkg::GS_DV_IDLE);
    assign dv.done = (st_r == gs_pkg::GS_DV_DONE);
    assign dv.quo = q_r;
    assign dv.rem = rm_r[30:0];
endmodule // gs_div

// ### hdl/gs_top.sv
// Purpose: electronic gear scaling and quadrature pulse re-output
// Assumes: encoder steps come from same-clock logic, one per cycle at most
// Notes: settings are taken while reset is high, i.e. at each restart

module gs_top
#(
    parameter int ENC_W = 20,
    parameter logic [20:0] ENC_RES = 21'h100000
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // settings, sampled at restart
    input wire logic [30:0] gear_numerator_i,
    input wire logic [30:0] gear_denominator_i,
    input wire logic [30:0] output_pulses_per_rev_i,
    input wire logic rotation_direction_select_i,
    // position reference in and scaled counts out
    input wire logic ref_valid_i,
    input wire logic signed [31:0] ref_units_i,
    output logic ref_ready_o,
    output logic cnt_valid_o,
    output logic signed [63:0] cnt_o,
    // encoder steps from the position logic
    input wire logic enc_step_i,
    input wire logic enc_dir_i,
    // alarms
    output logic param_alarm_o,
    output logic pulse_alarm_o,
    // pulse outputs to the host
    output logic quad_a_out_o,
    output logic quad_a_out_n_o,
    output logic quad_b_out_o,
    output logic quad_b_out_n_o,
    output logic origin_pulse_out_o,
    output logic origin_pulse_out_n_o
);
    gs_div_if dv ();

    logic [30:0] num_r, num_nxt, den_r, den_nxt, pls_r, pls_nxt;
    logic rev_r, rev_nxt, palm_r, palm_nxt, qalm_r, qalm_nxt;
    logic [20:0] inc_r, inc_nxt;
    logic busy_r, busy_nxt, neg_r, neg_nxt, vld_r, vld_nxt;
    logic signed [31:0] acc_rem_r, acc_rem_nxt;
    logic signed [63:0] cnt_r, cnt_nxt, prod;
    logic [ENC_W-1:0] pos_r, pos_nxt;
    logic [21:0] dda_r, dda_nxt, dda_t;
    logic [1:0] ph_r, ph_nxt, oc_r, oc_nxt;
    logic org_r, org_nxt, wrap, edge_s, fwd;
    logic [42:0] lo_l, lo_r, hi_l, hi_r;
    logic [32:0] inc_w;

    gs_div u_div
    (
        .core_clk_i (core_clk_i),
        .sys_rst_i (sys_rst_i),
        .dv (dv)
    );

    // settings: take ports at restart, zero picks factory value
    always_comb
    begin
        num_nxt = num_r;
        den_nxt = den_r;
        pls_nxt = pls_r;
        rev_nxt = rev_r;
        if (sys_rst_i)
        begin
            num_nxt = (gear_numerator_i == 31'h0) ? gs_pkg::GS_NUM_RST
                : gear_numerator_i;
            den_nxt = (gear_denominator_i == 31'h0) ? gs_pkg::GS_DEN_RST
                : gear_denominator_i;
            pls_nxt = (output_pulses_per_rev_i == 31'h0)
                ? gs_pkg::GS_PLS_RST : output_pulses_per_rev_i;
            rev_nxt = rotation_direction_select_i;
        end
    end

    always_comb
    begin
        lo_l = 43'(num_r) * 43'(gs_pkg::GS_RATIO_LO_DIV);
        lo_r = 43'(den_r);
        hi_l = 43'(num_r);
        hi_r = 43'(den_r) * 43'(gs_pkg::GS_RATIO_HI);
        palm_nxt = (lo_l < lo_r) || (hi_l > hi_r)
            || (num_r > gs_pkg::GS_GEAR_MAX) || (den_r > gs_pkg::GS_GEAR_MAX);
        inc_w = 33'(pls_r) * 33'(gs_pkg::GS_EDGES_CYC);
        qalm_nxt = (pls_r < gs_pkg::GS_PLS_MIN)
            || (pls_r > gs_pkg::GS_PLS_MAX) || (inc_w > 33'(ENC_RES));
        inc_nxt = (inc_w > 33'(ENC_RES)) ? ENC_RES : inc_w[20:0];
    end

    // one reference of ref_units_i units per host step
    // multiply, then divide with remainder carried forward
    always_comb
    begin
        busy_nxt = busy_r;
        neg_nxt = neg_r;
        vld_nxt = 1'b0;
        acc_rem_nxt = acc_rem_r;
        cnt_nxt = cnt_r;
        prod = ref_units_i * $signed({33'h0, num_r})
            + 64'(acc_rem_r);
        dv.start = 1'b0;
        dv.dvd = prod[63] ? 64'(-prod) : prod;
        dv.dvs = den_r;
        if (!busy_r && !dv.busy && ref_valid_i)
        begin
            dv.start = 1'b1;
            busy_nxt = 1'b1;
            neg_nxt = prod[63];
        end
        else if (busy_r && dv.done)
        begin
            busy_nxt = 1'b0;
            vld_nxt = 1'b1;
            cnt_nxt = neg_r ? -$signed(dv.quo) : $signed(dv.quo);
            acc_rem_nxt = neg_r ? -$signed({1'b0, dv.rem})
                : $signed({1'b0, dv.rem});
        end
    end

    // reverse mode restores the forward sense
    always_comb
    begin
        fwd = enc_dir_i ^ rev_r;
        pos_nxt = pos_r;
        wrap = 1'b0;
        if (enc_step_i && fwd)
        begin
            wrap = (pos_r == ENC_W'(ENC_RES - 21'h1));
            pos_nxt = wrap ? '0 : pos_r + ENC_W'(1);
        end
        else if (enc_step_i)
        begin
            wrap = (pos_r == '0);
            pos_nxt = wrap ? ENC_W'(ENC_RES - 21'h1) : pos_r - ENC_W'(1);
        end
    end

    // rate divider: 4*pulses edges per revolution exactly, capped at ENC_RES edges
    always_comb
    begin
        dda_nxt = dda_r;
        edge_s = 1'b0;
        dda_t = 22'h0;
        if (enc_step_i && fwd)
        begin
            dda_t = dda_r + 22'(inc_r);
            edge_s = (dda_t >= 22'(ENC_RES));
            dda_nxt = edge_s ? dda_t - 22'(ENC_RES) : dda_t;
        end
        else if (enc_step_i)
        begin
            edge_s = (dda_r < 22'(inc_r));
            dda_nxt = edge_s ? dda_r + 22'(ENC_RES) - 22'(inc_r)
                : dda_r - 22'(inc_r);
        end
    end

    // quadrature phase index, a leads b going forward
    // origin held for two edges, one phase a pulse
    always_comb
    begin
        ph_nxt = ph_r;
        if (edge_s)
            ph_nxt = fwd ? ph_r + 2'h1 : ph_r - 2'h1;
        org_nxt = org_r;
        oc_nxt = oc_r;
        if (wrap)
        begin
            org_nxt = 1'b1;
            oc_nxt = 2'h0;
        end
        else if (org_r && edge_s)
        begin
            oc_nxt = oc_r + 2'h1;
            if (oc_r + 2'h1 == gs_pkg::GS_ORG_EDGES)
                org_nxt = 1'b0;
        end
    end

    // all state registers
    always_ff @(posedge core_clk_i)
    begin
        num_r <= num_nxt;
        den_r <= den_nxt;
        pls_r <= pls_nxt;
        rev_r <= rev_nxt;
        if (sys_rst_i)
        begin
            palm_r <= 1'b0;
            qalm_r <= 1'b0;
            inc_r <= 21'h0;
            busy_r <= 1'b0;
            neg_r <= 1'b0;
            vld_r <= 1'b0;
            acc_rem_r <= 32'sh0;
            cnt_r <= 64'sh0;
            pos_r <= '0;
            dda_r <= 22'h0;
            ph_r <= 2'h0;
            org_r <= 1'b0;
            oc_r <= 2'h0;
        end
        else
        begin
            palm_r <= palm_nxt;
            qalm_r <= qalm_nxt;
            inc_r <= inc_nxt;
            busy_r <= busy_nxt;
            neg_r <= neg_nxt;
            vld_r <= vld_nxt;
            acc_rem_r <= acc_rem_nxt;
            cnt_r <= cnt_nxt;
            pos_r <= pos_nxt;
            dda_r <= dda_nxt;
            ph_r <= ph_nxt;
            org_r <= org_nxt;
            oc_r <= oc_nxt;
        end
    end

    // output flops; inverted twins
    always_ff @(posedge core_clk_i)
    begin
        ref_ready_o <= !sys_rst_i && !busy_nxt;
        cnt_valid_o <= !sys_rst_i && vld_nxt;
        cnt_o <= sys_rst_i ? 64'sh0 : cnt_nxt;
        param_alarm_o <= !sys_rst_i && palm_nxt;
        pulse_alarm_o <= !sys_rst_i && qalm_nxt;
        quad_a_out_o <= !sys_rst_i && (ph_nxt == 2'h1 || ph_nxt == 2'h2);
        quad_a_out_n_o <= sys_rst_i || !(ph_nxt == 2'h1 || ph_nxt == 2'h2);
        quad_b_out_o <= !sys_rst_i && ph_nxt[1];
        quad_b_out_n_o <= sys_rst_i || !ph_nxt[1];
        origin_pulse_out_o <= !sys_rst_i && org_nxt;
        origin_pulse_out_n_o <= sys_rst_i || !org_nxt;
    end

    // checks
    comp_a_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) quad_a_out_o != quad_a_out_n_o)
        else $error("a twin equal");
    comp_c_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) origin_pulse_out_o != origin_pulse_out_n_o)
        else $error("origin twin equal");
    quad_step_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        !($changed(quad_a_out_o) && $changed(quad_b_out_o)))
        else $error("a and b moved together");
    ratio_alarm_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) !$past(sys_rst_i) |->
        param_alarm_o == ((43'(num_r) * 43'h3E8 < 43'(den_r))
        || (43'(num_r) > 43'(den_r) * 43'hFA0)))
        else $error("ratio alarm wrong");
    setting_hold_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) ##1 $stable(num_r) && $stable(den_r))
        else $error("gear setting moved outside restart");
    origin_rev_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        $rose(origin_pulse_out_o) |-> $past(wrap))
        else $error("origin without revolution wrap");
    origin_width_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        org_r && edge_s && oc_r == 2'h1 && !wrap |=> !origin_pulse_out_o)
        else $error("origin wider than phase a pulse");
    gear_answer_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        ref_valid_i && ref_ready_o |-> ##66 cnt_valid_o)
        else $error("scaled count late");
    fwd_lead_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        edge_s && fwd && ph_r == 2'h0 |=> quad_a_out_o && !quad_b_out_o)
        else $error("forward phase form wrong");
endmodule // gs_top

// ### sim/gs_host_model.sv
// Purpose: host receiver decoding quadrature and origin feedback
// Assumes: lines sampled on the drive clock, no noise filter
// Notes: counts broken pairs and illegal phase jumps as errors
module gs_host_model
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // pulse lines from the drive
    input wire logic quad_a_i,
    input wire logic quad_a_n_i,
    input wire logic quad_b_i,
    input wire logic quad_b_n_i,
    input wire logic origin_i,
    input wire logic origin_n_i,
    // decoded feedback
    output logic signed [31:0] pos_o,
    output logic [31:0] edges_o,
    output logic [31:0] origins_o,
    output logic [31:0] org_width_o,
    output logic [31:0] errs_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] idx_r;
    logic org_r;
    logic [31:0] run_w_r;
    logic [1:0] idx;
    logic [1:0] dlt;
    logic moved;
    // gray phase index, forward counts up when a leads b
    assign idx = {quad_b_i, quad_a_i ^ quad_b_i};
    assign dlt = idx - idx_r;
    assign moved = (dlt != 2'h0);
    // decode, pair check and origin width measure
    always @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            idx_r <= idx;
            org_r <= 1'b0;
            run_w_r <= '0;
            pos_o <= '0;
            edges_o <= '0;
            origins_o <= '0;
            org_width_o <= '0;
            errs_o <= '0;
        end
        else
        begin
            idx_r <= idx;
            org_r <= origin_i;
            if (quad_a_i === quad_a_n_i || quad_b_i === quad_b_n_i ||
                origin_i === origin_n_i)
                errs_o <= errs_o + 1;
            if (dlt == 2'h1)
                pos_o <= pos_o + 1;
            if (dlt == 2'h3)
                pos_o <= pos_o - 1;
            if (dlt == 2'h2)
                errs_o <= errs_o + 1;
            if (moved)
                edges_o <= edges_o + 1;
            if (origin_i && !org_r)
                origins_o <= origins_o + 1;
            if (org_r)
                run_w_r <= run_w_r + 32'(moved);
            if (org_r && !origin_i)
            begin
                org_width_o <= run_w_r + 32'(moved);
                run_w_r <= '0;
            end
        end
    end
endmodule // gs_host_model

// ### sim/tb_top.sv
// Purpose: self-checking bench for gear scaling and pulse output
// Assumes: one revolution shortened to 256 encoder counts
// Notes: settings are applied by a restart before each scenario
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [30:0] num = '0;
    logic [30:0] den = '0;
    logic [30:0] pls = '0;
    logic rev = 1'b0;
    logic ref_valid = 1'b0;
    logic signed [31:0] ref_units = '0;
    logic enc_step = 1'b0;
    logic enc_dir = 1'b0;
    logic ref_ready, cnt_valid, param_alarm, pulse_alarm;
    logic signed [63:0] cnt;
    logic qa, qan, qb, qbn, oc, ocn;
    logic signed [31:0] h_pos;
    logic [31:0] h_edges, h_orgs, h_width, h_errs;
    int miscompares = 0;
    int tests_run = 0;
    // design with a short revolution
    gs_top #(.ENC_W(8), .ENC_RES(21'h000100)) dut_u (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .gear_numerator_i(num), .gear_denominator_i(den),
        .output_pulses_per_rev_i(pls),
        .rotation_direction_select_i(rev),
        .ref_valid_i(ref_valid), .ref_units_i(ref_units),
        .ref_ready_o(ref_ready), .cnt_valid_o(cnt_valid), .cnt_o(cnt),
        .enc_step_i(enc_step), .enc_dir_i(enc_dir),
        .param_alarm_o(param_alarm), .pulse_alarm_o(pulse_alarm),
        .quad_a_out_o(qa), .quad_a_out_n_o(qan),
        .quad_b_out_o(qb), .quad_b_out_n_o(qbn),
        .origin_pulse_out_o(oc), .origin_pulse_out_n_o(ocn));
    // host receiving the feedback
    gs_host_model host_u (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .quad_a_i(qa), .quad_a_n_i(qan), .quad_b_i(qb), .quad_b_n_i(qbn),
        .origin_i(oc), .origin_n_i(ocn), .pos_o(h_pos),
        .edges_o(h_edges), .origins_o(h_orgs), .org_width_o(h_width),
        .errs_o(h_errs));
    // clock generator
    initial
    begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    // compare and report
    task automatic check(logic [63:0] seen, logic [63:0] exp, string what);
        tests_run++;
        if (seen !== exp)
        begin
            $display("unexpected at %0t: %s", $time, what);
            miscompares++;
        end
    endtask
    // verdict and end of run
    task automatic finish_test();
        $display("mismatches %0d of %0d checks", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // restart with new settings, then let alarms settle
    task automatic restart(logic [30:0] n, logic [30:0] d,
                           logic [30:0] p, logic r);
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        num <= n;
        den <= d;
        pls <= p;
        rev <= r;
        repeat (4) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
    endtask
    // one reference through the scaler
    task automatic do_ref(logic signed [31:0] v, logic signed [63:0] exp);
        int n;
        @(posedge core_clk_i);
        ref_valid <= 1'b1;
        ref_units <= v;
        n = 0;
        do
        begin
            @(posedge core_clk_i);
            n++;
        end
        while (ref_ready !== 1'b1 && n < 100);
        if (ref_ready !== 1'b1)
        begin
            miscompares++;
            finish_test();
        end
        ref_valid <= 1'b0;
        n = 0;
        do
        begin
            @(posedge core_clk_i);
            n++;
        end
        while (cnt_valid !== 1'b1 && n < 200);
        if (cnt_valid !== 1'b1)
        begin
            miscompares++;
            finish_test();
        end
        check(cnt, exp, "scaled count");
    endtask
    // encoder counts, one every four cycles
    task automatic steps(int n, logic d);
        repeat (n)
        begin
            @(posedge core_clk_i);
            enc_step <= 1'b1;
            enc_dir <= d;
            @(posedge core_clk_i);
            enc_step <= 1'b0;
            repeat (2) @(posedge core_clk_i);
        end
        repeat (4) @(posedge core_clk_i);
    endtask
    // alarm windows for gear ratio and pulse setting
    task automatic sc_alarms();
        logic [30:0] tn[6] = '{31'h0, 31'h1, 31'h1, 31'hFA0, 31'hFA1,
                               31'h40000000};
        logic [30:0] td[6] = '{31'h0, 31'h3E9, 31'h3E8, 31'h1, 31'h1,
                               31'h40000000};
        logic [30:0] tp[6] = '{31'h0, 31'h10, 31'h40, 31'hF, 31'h41,
                               31'h40000001};
        logic ep[6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        logic eu[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
        for (int i = 0; i < 6; i++)
        begin
            restart(tn[i], td[i], tp[i], 1'b0);
            check(64'(param_alarm), 64'(ep[i]), "gear alarm");
            check(64'(pulse_alarm), 64'(eu[i]), "pulse alarm");
        end
    endtask
    // scaling with factory and odd ratios, remainder carried
    task automatic sc_scaling();
        restart(31'h0, 31'h0, 31'h10, 1'b0);
        do_ref(32'sd100, 64'sd400);
        restart(31'h3, 31'h2, 31'h10, 1'b0);
        do_ref(-32'sd7, -64'sd10);
        do_ref(-32'sd1, -64'sd2);
        restart(31'h00100000, 31'h00001770, 31'h10, 1'b0);
        do_ref(32'sd10000, 64'sd1747626);
        do_ref(32'sd10000, 64'sd1747627);
    endtask
    // pulse output, both directions and reverse mode
    task automatic sc_encoder();
        restart(31'h1, 31'h1, 31'h10, 1'b0);
        // host turns two revolutions before trusting origin
        steps(512, 1'b1);
        check(64'(h_edges), 64'd128, "edges per two turns");
        check(64'(h_pos), 64'd128, "a leads b forward");
        check(64'(h_orgs), 64'd2, "origins forward");
        check(64'(h_width), 64'd2, "origin width");
        steps(512, 1'b0);
        check(64'(h_pos), 64'd0, "back to start");
        // turning back at the index merges with the still-high origin
        check(64'(h_orgs), 64'd3, "origins reverse");
        check(64'(h_errs), 64'd0, "pairs and phase jumps");
        restart(31'h1, 31'h1, 31'h10, 1'b1);
        steps(256, 1'b0);
        check(64'(h_pos), 64'd64, "reverse mode phase");
        check(64'(h_orgs), 64'd1, "reverse mode origin");
        check(64'(h_errs), 64'd0, "reverse mode pairs");
    endtask
    // main sequence
    initial
    begin
        repeat (4) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        check(64'(ref_ready), 64'd1, "ready after reset");
        sc_alarms();
        sc_scaling();
        sc_encoder();
        finish_test();
    end
endmodule // tb_top
